// [stre_exec.sv]
// The implementer's own choices: the address-and-strobe port and the address map.
`timescale 1ns/10ps
`default_nettype none
`include "stre_map.svh"
// Notes on behaviour
// - file-borrow subtract: W minus f minus not-carry
// - d=0 writes W, d=1 writes file
// - a=0 access bank, a=1 uses bank select
// - literal subtract: k minus W into W
// - table read two cycles, latch second cycle
module stre_exec
    import stre_pkg::*;
#(
    parameter int PTR_W = `STRE_PTR_W
)
(
    // clock and reset
    input  wire logic             mclk,
    input  wire logic             rst_b,
    // instruction issue
    input  wire logic             instr_valid,
    input  wire logic [15:0]      opcode,
    // bank select register value from the core
    input  wire logic [3:0]       bank_select_register,
    // file operand read data for the resolved address
    input  wire logic [7:0]       file_rdata,
    // file write port
    output logic [11:0]           file_addr,
    output logic                  file_we,
    output logic [7:0]            file_wdata,
    // program memory
    output logic [PTR_W-1:0]      prog_addr,
    output logic                  prog_re,
    input  wire logic [7:0]       prog_rdata,
    // architectural state
    output logic [7:0]            work_q,
    output logic                  carry_q,
    output logic                  zero_q,
    output logic                  neg_q,
    output logic [PTR_W-1:0]      table_pointer,
    output logic [7:0]            table_latch,
    output logic                  busy
);
    stre_state_type state_q;
    logic [PTR_W-1:0] ptr_q;
    logic [PTR_W-1:0] ptr_nx;
    logic [PTR_W-1:0] fetch_a;
    logic [PTR_W-1:0] fetch_q;
    logic [7:0] lat_q;
    logic [7:0] sa;
    logic [7:0] sb;
    logic       sbr;
    logic [7:0] sres;
    logic       sc;
    logic       sz;
    logic       sn;
    logic       is_fwb;
    logic       is_wfb;
    logic       is_wf;
    logic       is_lw;
    logic       is_tbl;
    logic       is_fsub;
    logic       go;

    // the three file-register subtract forms share d, a and flag handling
    function automatic logic file_sub_form(input logic [15:0] op);
        return (op[15:10] == `STRE_OP_SUB_FILE_FROM_WORK_BORROW_HI) || (op[15:10] == `STRE_OP_SUB_WORK_FROM_FILE_BORROW_HI)
            || (op[15:10] == `STRE_OP_SUB_WORK_FROM_FILE_HI);
    endfunction

    assign go     = instr_valid && (state_q == ST_IDLE);
    assign is_fwb = (opcode[15:10] == `STRE_OP_SUB_FILE_FROM_WORK_BORROW_HI);
    assign is_wfb = (opcode[15:10] == `STRE_OP_SUB_WORK_FROM_FILE_BORROW_HI);
    assign is_wf  = (opcode[15:10] == `STRE_OP_SUB_WORK_FROM_FILE_HI);
    assign is_lw  = (opcode[15:8] == `STRE_OP_SUB_WORK_FROM_LITERAL_HI);
    assign is_tbl = (opcode[15:2] == `STRE_OP_TBL_HI);
    assign is_fsub = file_sub_form(opcode);

    // bank from opcode a bit; core supplies matching read data
    assign file_addr = opcode[`STRE_A_BIT] ? {bank_select_register, opcode[7:0]}
                                           : {`STRE_ACC_BANK, opcode[7:0]};

    // operand steering
    always_comb
    begin
        sa  = file_rdata;
        sb  = work_q;
        sbr = 1'b0;
        if (is_fwb)
        begin
            sa  = work_q;
            sb  = file_rdata;
            sbr = ~carry_q;
        end
        else if (is_wfb)
        begin
            sbr = ~carry_q;
        end
        else if (is_lw)
        begin
            sa = opcode[7:0];
        end
    end

    stre_sub u_sub (
        .a         (sa),
        .b         (sb),
        .borrow_in (sbr),
        .res       (sres),
        .carry     (sc),
        .zero      (sz),
        .neg       (sn)
    );

    stre_ptr #(.PTR_W(PTR_W)) u_ptr (
        .ptr        (ptr_q),
        .act        (opcode[1:0]),
        .fetch_addr (fetch_a),
        .ptr_next   (ptr_nx)
    );

    // file write back only when d=1
    assign file_we    = go && is_fsub && opcode[`STRE_D_BIT];
    assign file_wdata = sres;

    always_ff @(posedge mclk or negedge rst_b)
    begin
        if (!rst_b)
            work_q <= `STRE_RST_BYTE;
        else if (go && is_lw)
            work_q <= sres;
        else if (go && is_fsub && !opcode[`STRE_D_BIT])
            work_q <= sres;
    end

    always_ff @(posedge mclk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            carry_q <= 1'b0;
            zero_q  <= 1'b0;
            neg_q   <= 1'b0;
        end
        else if (go && (is_fsub || is_lw))
        begin
            carry_q <= sc;
            zero_q  <= sz;
            neg_q   <= sn;
        end
    end

    // table read: issue cycle then fetch cycle
    always_ff @(posedge mclk or negedge rst_b)
    begin
        if (!rst_b)
            state_q <= ST_IDLE;
        else
            case (state_q)
                ST_IDLE:      if (go && is_tbl) state_q <= ST_TBL_FETCH;
                ST_TBL_FETCH: state_q <= ST_IDLE;
                default:      state_q <= ST_IDLE;
            endcase
    end

    always_ff @(posedge mclk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            ptr_q   <= '0;
            fetch_q <= '0;
        end
        else if (go && is_tbl)
        begin
            ptr_q   <= ptr_nx;
            fetch_q <= fetch_a;
        end
    end

    // memory read in the second cycle; data taken at its end
    assign prog_addr = fetch_q;
    assign prog_re   = (state_q == ST_TBL_FETCH);

    always_ff @(posedge mclk or negedge rst_b)
    begin
        if (!rst_b)
            lat_q <= `STRE_RST_BYTE;
        else if (state_q == ST_TBL_FETCH)
            lat_q <= prog_rdata;
    end

    assign table_pointer = ptr_q;
    assign table_latch   = lat_q;
    assign busy          = (state_q != ST_IDLE);

    tbl_two_cycle_a: assert property (@(posedge mclk) disable iff (!rst_b)
        (go && is_tbl)
        |=> prog_re ##1 !prog_re)
        else $error("table read not two cycles");

    tbl_latch_a: assert property (@(posedge mclk) disable iff (!rst_b)
        prog_re
        |=> (table_latch == $past(prog_rdata)))
        else $error("table latch not loaded");

    lit_sub_a: assert property (@(posedge mclk) disable iff (!rst_b)
        (go && is_lw)
        |=> (work_q == 8'($past(opcode[7:0]) - $past(work_q))))
        else $error("literal subtract wrong");

    dest_file_a: assert property (@(posedge mclk) disable iff (!rst_b)
        (go && is_fsub && opcode[`STRE_D_BIT])
        |-> file_we ##1 $stable(work_q))
        else $error("work changed on file destination");

    dest_work_a: assert property (@(posedge mclk) disable iff (!rst_b)
        (go && is_fsub && !opcode[`STRE_D_BIT])
        |-> !file_we ##1 (work_q == $past(file_wdata)))
        else $error("file written on work destination");

    fwb_res_a: assert property (@(posedge mclk) disable iff (!rst_b)
        (go && is_fwb)
        |-> (sres == 8'(work_q - file_rdata - {7'h00, ~carry_q})))
        else $error("borrow subtract wrong");

    wf_res_a: assert property (@(posedge mclk) disable iff (!rst_b)
        (go && is_wf)
        |-> (file_wdata == 8'(file_rdata - work_q)))
        else $error("file subtract wrong");

    wfb_res_a: assert property (@(posedge mclk) disable iff (!rst_b)
        (go && is_wfb)
        |-> (file_wdata == 8'(file_rdata - work_q - {7'h00, ~carry_q})))
        else $error("file borrow subtract wrong");

    fwb_carry_a: assert property (@(posedge mclk) disable iff (!rst_b)
        (go && is_fwb)
        |-> (sc == ({1'b0, work_q} >= ({1'b0, file_rdata} + {8'h00, ~carry_q}))))
        else $error("borrow subtract carry wrong");

    bank_sel_a: assert property (@(posedge mclk) disable iff (!rst_b)
        !opcode[8]
        |-> (file_addr[11:8] == 4'h0))
        else $error("access bank not used");

    bank_use_a: assert property (@(posedge mclk) disable iff (!rst_b)
        opcode[8]
        |-> (file_addr[11:8] == bank_select_register))
        else $error("bank select not used");

    file_off_a: assert property (@(posedge mclk) disable iff (!rst_b)
        instr_valid
        |-> (file_addr[7:0] == opcode[7:0]))
        else $error("file offset not passed through");

    post_inc_a: assert property (@(posedge mclk) disable iff (!rst_b)
        (go && is_tbl && opcode[1:0] == 2'b01)
        |=> (table_pointer == $past(table_pointer) + 1'b1)
        && (prog_addr == $past(table_pointer)))
        else $error("post increment wrong");

    post_dec_a: assert property (@(posedge mclk) disable iff (!rst_b)
        (go && is_tbl && opcode[1:0] == 2'b10)
        |=> (table_pointer == $past(table_pointer) - 1'b1)
        && (prog_addr == $past(table_pointer)))
        else $error("post decrement wrong");

    pre_inc_a: assert property (@(posedge mclk) disable iff (!rst_b)
        (go && is_tbl && opcode[1:0] == 2'b11)
        |=> (prog_addr == table_pointer)
        && (table_pointer == $past(table_pointer) + 1'b1))
        else $error("pre increment wrong");

    ptr_keep_a: assert property (@(posedge mclk) disable iff (!rst_b)
        (go && is_tbl && opcode[1:0] == 2'b00)
        |=> $stable(table_pointer) && (prog_addr == table_pointer))
        else $error("pointer moved on plain read");

    ptr_idle_a: assert property (@(posedge mclk) disable iff (!rst_b)
        !(go && is_tbl)
        |=> $stable(table_pointer))
        else $error("pointer moved without table read");

    busy_refuse_a: assert property (@(posedge mclk) disable iff (!rst_b)
        busy
        |=> !busy && $stable(work_q) && $stable(carry_q))
        else $error("instruction taken during table fetch");

    latch_hold_a: assert property (@(posedge mclk) disable iff (!rst_b)
        !prog_re
        |=> $stable(table_latch))
        else $error("table latch changed outside fetch");

    flag_zero_a: assert property (@(posedge mclk) disable iff (!rst_b)
        (go && is_lw && opcode[7:0] == work_q)
        |=> (zero_q && carry_q && !neg_q))
        else $error("flags wrong on zero result");

    lit_flags_a: assert property (@(posedge mclk) disable iff (!rst_b)
        (go && is_lw)
        |=> (carry_q == ($past(opcode[7:0]) >= $past(work_q)))
        && (neg_q == work_q[7])
        && (zero_q == (work_q == 8'h00)))
        else $error("literal subtract flags wrong");

    tbl_flags_a: assert property (@(posedge mclk) disable iff (!rst_b)
        (go && is_tbl)
        |=> $stable(carry_q) && $stable(zero_q) && $stable(neg_q))
        else $error("flags changed by table read");
endmodule // stre_exec
`default_nettype wire

// [stre_map.svh]
`ifndef STRE_MAP_SVH
`define STRE_MAP_SVH
// opcode fields
`define STRE_OP_SUB_FILE_FROM_WORK_BORROW_HI   6'b0101_01
`define STRE_OP_SUB_WORK_FROM_FILE_BORROW_HI   6'b0101_10
`define STRE_OP_SUB_WORK_FROM_FILE_HI    6'b0101_11
`define STRE_OP_SUB_WORK_FROM_LITERAL_HI    8'h08
`define STRE_OP_TBL_HI      14'h0002
`define STRE_D_BIT          9
`define STRE_A_BIT          8
`define STRE_PTR_W          21
`define STRE_ACC_BANK       4'h0
`define STRE_RST_BYTE       8'h00
`define STRE_TBL_CYCLES     2
`endif

// [stre_pkg.sv]
`default_nettype none
package stre_pkg;
    typedef enum logic [1:0] {
        TP_KEEP = 2'b00,
        TP_POST_INC = 2'b01,
        TP_POST_DEC = 2'b10,
        TP_PRE_INC = 2'b11
    } stre_ptr_act_type;
    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_TBL_FETCH = 2'b01
    } stre_state_type;
endpackage
`default_nettype wire

// [stre_sub.sv]
`timescale 1ns/10ps
`default_nettype none
// a - b - borrow_in, flags per subtraction convention
module stre_sub
    import stre_pkg::*;
(
    // operands
    input  wire logic [7:0] a,
    input  wire logic [7:0] b,
    input  wire logic       borrow_in,
    // result
    output logic [7:0]      res,
    output logic            carry,
    output logic            zero,
    output logic            neg
);
    logic [8:0] diff;
    // borrow out lands in bit 8; carry is its inverse
    assign diff  = {1'b0, a} - {1'b0, b} - {8'h00, borrow_in};
    assign res   = diff[7:0];
    assign carry = ~diff[8];
    assign zero  = (diff[7:0] == 8'h00);
    assign neg   = diff[7];
endmodule // stre_sub
`default_nettype wire

// [stre_ptr.sv]
`timescale 1ns/10ps
`default_nettype none
`include "stre_map.svh"
module stre_ptr
    import stre_pkg::*;
#(
    parameter int PTR_W = `STRE_PTR_W
)
(
    // pointer action
    input  wire logic [PTR_W-1:0] ptr,
    input  wire logic [1:0]       act,
    // results
    output logic [PTR_W-1:0]      fetch_addr,
    output logic [PTR_W-1:0]      ptr_next
);
    always_comb
    begin
        fetch_addr = ptr;
        ptr_next   = ptr;
        case (act)
            TP_POST_INC: ptr_next = ptr + PTR_W'(1);
            TP_POST_DEC: ptr_next = ptr - PTR_W'(1);
            TP_PRE_INC:
            begin
                fetch_addr = ptr + PTR_W'(1);
                ptr_next   = fetch_addr;
            end
            default: ptr_next = ptr;
        endcase
    end
endmodule // stre_ptr
`default_nettype wire

// [stre_tb.sv]
`timescale 1ns/10ps
`default_nettype none
module testbench
    import stre_pkg::*;
;
    logic        mclk;
    logic        rst_b;
    logic        instr_valid;
    logic [15:0] opcode;
    logic [3:0]  bank_select_register;
    logic [7:0]  file_rdata;
    logic [11:0] file_addr;
    logic        file_we;
    logic [7:0]  file_wdata;
    logic [20:0] prog_addr;
    logic        prog_re;
    logic [7:0]  prog_rdata;
    logic [7:0]  work_q;
    logic        carry_q;
    logic        zero_q;
    logic        neg_q;
    logic [20:0] table_pointer;
    logic [7:0]  table_latch;
    logic        busy;
    int          miscompares;
    int          checks;

    stre_exec dut (.mclk, .rst_b, .instr_valid, .opcode, .bank_select_register, .file_rdata,
        .file_addr, .file_we, .file_wdata, .prog_addr, .prog_re, .prog_rdata, .work_q,
        .carry_q, .zero_q, .neg_q, .table_pointer, .table_latch, .busy);

    task automatic end_sim;
        $display("checks %0d miscompares %0d", checks, miscompares);
        if (miscompares == 0 && checks > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp)
        begin
            miscompares++;
            $display("[FAIL] %0t got %h exp %h", $time, got, exp);
        end
    endtask

    // inputs move by non-blocking assignment at the edge, sampled by the DUT at the next edge; the task returns 1 ns later
    task automatic issue(input logic [15:0] op, input logic [7:0] d);
        @(posedge mclk);
        instr_valid <= 1'b1;
        opcode <= op;
        file_rdata <= d;
        prog_rdata <= d;
        #1;
    endtask

    task automatic retire;
        @(posedge mclk);
        instr_valid <= 1'b0;
        #1;
    endtask

    task automatic lit(input logic [7:0] k, input logic [10:0] e);
        issue({8'h08, k}, 8'h00);
        retire;
        chk(32'({work_q, carry_q, zero_q, neg_q}), 32'(e));
    endtask

    task automatic sub_op(input logic [15:0] op, input logic [7:0] d, input logic [11:0] a,
        input logic we, input logic [7:0] wd, input logic [10:0] e);
        issue(op, d);
        chk(32'({file_addr, file_we}), 32'({a, we}));
        if (we)
            chk(32'(file_wdata), 32'(wd));
        retire;
        chk(32'({work_q, carry_q, zero_q, neg_q}), 32'(e));
    endtask

    task automatic test_lit;
        lit(8'h02, {8'h02, 3'b100});
        lit(8'h02, {8'h00, 3'b110});
        lit(8'h03, {8'h03, 3'b100});
        lit(8'h02, {8'hFF, 3'b001});
        lit(8'h04, {8'h05, 3'b000});
        $display("test literal subtract done");
    endtask

    task automatic test_file;
        sub_op(16'h5534, 8'h02, 12'hA34, 1'b0, 8'h00, {8'h02, 3'b100});
        sub_op(16'h5534, 8'h02, 12'hA34, 1'b0, 8'h00, {8'h00, 3'b110});
        sub_op(16'h5A20, 8'h03, 12'h020, 1'b1, 8'h03, {8'h00, 3'b100});
        lit(8'h02, {8'h02, 3'b100});
        sub_op(16'h5E10, 8'h01, 12'h010, 1'b1, 8'hFF, {8'h02, 3'b001});
        sub_op(16'h591B, 8'h1B, 12'hA1B, 1'b0, 8'h00, {8'h18, 3'b100});
        sub_op(16'h5734, 8'h08, 12'hA34, 1'b1, 8'h10, {8'h18, 3'b100});
        $display("test file subtract done");
    endtask

    // pointer starts at zero after reset; the post-increment before the post-decrement keeps it from wrapping
    task automatic test_table;
        logic [20:0] fa [4];
        logic [20:0] np [4];
        fa = '{21'h0, 21'h0, 21'h1, 21'h1};
        np = '{21'h0, 21'h1, 21'h0, 21'h1};
        for (int i = 0; i < 4; i++)
        begin
            issue({14'h0002, i[1:0]}, 8'(8'h30 + i));
            // a literal subtract offered while busy must be dropped
            @(posedge mclk);
            opcode <= 16'h08FF;
            #1;
            chk(32'({prog_re, busy, prog_addr}), 32'({2'b11, fa[i]}));
            chk(32'(table_pointer), 32'(np[i]));
            retire;
            chk(32'({prog_re, table_latch}), 32'(8'h30 + i));
        end
        chk(32'(work_q), 32'(8'h18));
        $display("test table read done");
    endtask

    initial
    begin
        mclk = 1'b0;
        forever #2 mclk = ~mclk;
    end

    initial
    begin
        #100000;
        miscompares++;
        end_sim;
    end

    initial
    begin
        rst_b = 1'b0;
        instr_valid = 1'b0;
        opcode = 16'h0000;
        bank_select_register = 4'hA;
        file_rdata = 8'h00;
        prog_rdata = 8'h00;
        miscompares = 0;
        checks = 0;
        repeat (8) @(posedge mclk);
        rst_b <= 1'b1;
        test_lit;
        test_file;
        test_table;
        end_sim;
    end
endmodule // testbench
`default_nettype wire
